// file: hdl/sra_defs.svh
// Register offsets, field positions, reset values and timing for the seconds RTC block
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH
`define SRA_ADDR_TALLY 16'h4020
`define SRA_ADDR_SEC_HI 16'h4021
`define SRA_ADDR_SEC_LO 16'h4022
`define SRA_ADDR_ALM_HI 16'h4023
`define SRA_ADDR_ALM_LO 16'h4024
`define SRA_ADDR_CTRL 16'h4025
`define SRA_ADDR_IRQ_STAT 16'h4030
`define SRA_ADDR_IRQ_MASK 16'h4031
`define SRA_CTRL_VALID_BIT 15
`define SRA_CTRL_BUSY_BIT 14
`define SRA_CTRL_ALM_EN_BIT 10
`define SRA_CTRL_SEL_MSB 6
`define SRA_CTRL_SEL_LSB 4
`define SRA_IRQ_ALARM_BIT 0
`define SRA_IRQ_PERIOD_BIT 1
`define SRA_SEC_RST 32'h0000_0000
`define SRA_ALARM_RST 16'h0000
`define SRA_TALLY_SEED 16'hACE1
`define SRA_TALLY_TAPS 16'hB400
`define SRA_SEL_OFF 3'h0
`define SRA_XTAL_HZ 32768
`define SRA_CLK_PERIOD_NS 10
`define SRA_SYNC_TIME_NS 200
`endif

// file: hdl/sra_pkg.sv
// Types shared by the seconds RTC block
package sra_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } sra_bus_s;

   typedef struct packed {
      logic [2:0] xsync;
      logic xlvl;
      logic [15:0] pre;
      logic [31:0] sec;
      logic [31:0] alm;
      logic [15:0] tally;
      logic valid;
      logic [4:0] busy_cnt;
      logic alm_en;
      logic [2:0] sel;
      logic [6:0] pcnt;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic irq;
      logic [15:0] rdata;
   } sra_state_s;
endpackage

// file: hdl/sra_top.sv
// Seconds counter, alarm, periodic interrupt and register slave of the RTC
`timescale 1ns/1ps
`include "sra_defs.svh"

// Overview of operation
// - Seconds write steps pseudo-random write tally
// - Seconds count advances by one per tick not met by a seconds write
// - Upper and lower seconds halves readable
// - Alarm time stored as two halves
// - Alarm halves reset to zero
// - Time-set flag sets after seconds write
// - Periodic interrupt, select doubles 2 to 128s
module sra_top
   import sra_pkg::*;
#(
   parameter int XTAL_PER_SEC = `SRA_XTAL_HZ
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic xtal_i,
   input wire sra_bus_s bus_i,
   output logic [15:0] rdata_o,
   output logic irq_o
);

   // *****************************************************
   // Timing
   // *****************************************************
   localparam int BUSY_CYCLES_INT =
      (`SRA_SYNC_TIME_NS + `SRA_CLK_PERIOD_NS - 1) / `SRA_CLK_PERIOD_NS;
   localparam logic [4:0] BUSY_CYCLES = 5'(BUSY_CYCLES_INT);
   localparam logic [15:0] PRE_LAST = 16'(XTAL_PER_SEC - 1);

   // *****************************************************
   // State
   // *****************************************************
   sra_state_s st;
   sra_state_s next_st;

   logic xtal_rise;
   logic tick;
   logic wr_sec_hi;
   logic wr_sec_lo;
   logic wr_alm_hi;
   logic wr_alm_lo;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic sec_write;
   logic [31:0] sec_inc;
   logic [6:0] pcnt_inc;
   logic [6:0] sel_mask;
   logic alarm_ev;
   logic period_ev;
   logic [1:0] events;
   logic [1:0] clear_bits;
   logic [15:0] ctrl_word;
   logic [15:0] rd_word;
   logic busy;
   logic pre_wrap;
   logic sec_step;
   logic alarm_hit;
   logic [15:0] tally_step;
   logic [6:0] next_pcnt;
   logic [1:0] next_stat;
   logic [1:0] next_mask;
   logic next_irq;

   // *****************************************************
   // Address decode
   // *****************************************************
   always_comb begin
      wr_sec_hi = 1'b0;
      wr_sec_lo = 1'b0;
      wr_alm_hi = 1'b0;
      wr_alm_lo = 1'b0;
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (bus_i.addr == `SRA_ADDR_SEC_HI) begin
         wr_sec_hi = bus_i.wr;
      end else if (bus_i.addr == `SRA_ADDR_SEC_LO) begin
         wr_sec_lo = bus_i.wr;
      end else if (bus_i.addr == `SRA_ADDR_ALM_HI) begin
         wr_alm_hi = bus_i.wr;
      end else if (bus_i.addr == `SRA_ADDR_ALM_LO) begin
         wr_alm_lo = bus_i.wr;
      end else if (bus_i.addr == `SRA_ADDR_CTRL) begin
         wr_ctrl = bus_i.wr;
      end else if (bus_i.addr == `SRA_ADDR_IRQ_STAT) begin
         wr_stat = bus_i.wr;
      end else if (bus_i.addr == `SRA_ADDR_IRQ_MASK) begin
         wr_mask = bus_i.wr;
      end
   end

   // Tally is read-only; a write to it is dropped
   assign sec_write = wr_sec_hi | wr_sec_lo;

   // *****************************************************
   // Read mux
   // *****************************************************
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[`SRA_CTRL_VALID_BIT] = st.valid;
      ctrl_word[`SRA_CTRL_BUSY_BIT] = busy;
      ctrl_word[`SRA_CTRL_ALM_EN_BIT] = st.alm_en;
      ctrl_word[`SRA_CTRL_SEL_MSB:`SRA_CTRL_SEL_LSB] = st.sel;
   end

   // Halves have no shadow latch: a high then low read can tear across
   // a tick, so software reads the high half again to catch a carry
   always_comb begin
      rd_word = 16'h0000;
      if (bus_i.addr == `SRA_ADDR_TALLY) begin
         rd_word = st.tally;
      end else if (bus_i.addr == `SRA_ADDR_SEC_HI) begin
         rd_word = st.sec[31:16];
      end else if (bus_i.addr == `SRA_ADDR_SEC_LO) begin
         rd_word = st.sec[15:0];
      end else if (bus_i.addr == `SRA_ADDR_ALM_HI) begin
         rd_word = st.alm[31:16];
      end else if (bus_i.addr == `SRA_ADDR_ALM_LO) begin
         rd_word = st.alm[15:0];
      end else if (bus_i.addr == `SRA_ADDR_CTRL) begin
         rd_word = ctrl_word;
      end else if (bus_i.addr == `SRA_ADDR_IRQ_STAT) begin
         rd_word = {14'h0000, st.irq_stat};
      end else if (bus_i.addr == `SRA_ADDR_IRQ_MASK) begin
         rd_word = {14'h0000, st.irq_mask};
      end
   end

   // *****************************************************
   // Crystal edge and one-second tick
   // *****************************************************
   // The filtered level only follows once the last two stages agree,
   // so a single metastable sample cannot make a false edge.
   assign xtal_rise = (st.xsync[1] == st.xsync[2]) & st.xsync[2] & ~st.xlvl;
   assign pre_wrap = (st.pre == PRE_LAST);
   assign tick = xtal_rise & pre_wrap;

   // *****************************************************
   // Events
   // *****************************************************
   assign sec_inc = st.sec + 32'h0000_0001;
   assign pcnt_inc = st.pcnt + 7'h01;
   assign sel_mask = 7'((8'h01 << st.sel) - 8'h01);

   // A tick that meets a seconds write is lost, and its events with it
   assign sec_step = tick & ~sec_write;
   // Alarm compares the value the count is about to take
   assign alarm_hit = (sec_inc == st.alm);
   assign alarm_ev = sec_step & st.alm_en & alarm_hit;
   // Period is 2 to the power of the select code
   assign period_ev = sec_step & (st.sel != `SRA_SEL_OFF) &
                      ((pcnt_inc & sel_mask) == 7'h00);

   always_comb begin
      events = 2'h0;
      events[`SRA_IRQ_ALARM_BIT] = alarm_ev;
      events[`SRA_IRQ_PERIOD_BIT] = period_ev;
   end

   assign clear_bits = wr_stat ? bus_i.wdata[1:0] : 2'h0;

   // *****************************************************
   // Busy flag, write tally, period phase and status
   // *****************************************************
   assign busy = (st.busy_cnt != 5'h00);

   always_comb begin
      // Galois LFSR step gives a fresh value per seconds write
      if (st.tally[0]) begin
         tally_step = (st.tally >> 1) ^ `SRA_TALLY_TAPS;
      end else begin
         tally_step = st.tally >> 1;
      end
   end

   // A new select restarts the period phase
   always_comb begin
      next_pcnt = st.pcnt;
      if (wr_ctrl) begin
         next_pcnt = 7'h00;
      end else if (sec_step) begin
         next_pcnt = pcnt_inc;
      end
   end

   always_comb begin
      // Sticky status: a new event wins over a clear in the same cycle
      next_stat = (st.irq_stat & ~clear_bits) | events;
      next_mask = st.irq_mask;
      if (wr_mask) begin
         next_mask = bus_i.wdata[1:0];
      end
      // The level follows the new status and mask on the same edge
      next_irq = |(next_stat & next_mask);
   end

   // *****************************************************
   // Next state
   // *****************************************************
   always_comb begin
      next_st = st;

      // Synchroniser: stage one only feeds stage two
      next_st.xsync = {st.xsync[1:0], xtal_i};
      if (st.xsync[1] == st.xsync[2]) begin
         next_st.xlvl = st.xsync[2];
      end

      // Prescaler
      if (xtal_rise) begin
         if (pre_wrap) begin
            next_st.pre = 16'h0000;
         end else begin
            next_st.pre = st.pre + 16'h0001;
         end
      end

      // Seconds count; a write restarts the current second
      if (sec_write) begin
         next_st.pre = 16'h0000;
         if (wr_sec_hi) begin
            next_st.sec[31:16] = bus_i.wdata;
         end
         if (wr_sec_lo) begin
            next_st.sec[15:0] = bus_i.wdata;
         end
         next_st.valid = 1'b1;
         // Nothing blocks a write while busy; the host waits for the flag
         next_st.busy_cnt = BUSY_CYCLES;
         next_st.tally = tally_step;
      end else begin
         if (sec_step) begin
            next_st.sec = sec_inc;
         end
         if (busy) begin
            next_st.busy_cnt = st.busy_cnt - 5'h01;
         end
      end

      // Alarm halves
      if (wr_alm_hi) begin
         next_st.alm[31:16] = bus_i.wdata;
      end
      if (wr_alm_lo) begin
         next_st.alm[15:0] = bus_i.wdata;
      end

      // Control
      if (wr_ctrl) begin
         next_st.alm_en = bus_i.wdata[`SRA_CTRL_ALM_EN_BIT];
         next_st.sel = bus_i.wdata[`SRA_CTRL_SEL_MSB:`SRA_CTRL_SEL_LSB];
      end
      next_st.pcnt = next_pcnt;

      // Status, mask and interrupt level
      next_st.irq_stat = next_stat;
      next_st.irq_mask = next_mask;
      next_st.irq = next_irq;

      // Read data stands for the one cycle after the strobe
      next_st.rdata = bus_i.rd ? rd_word : 16'h0000;
   end

   // *****************************************************
   // Registers
   // *****************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st.xsync <= 3'h0;
         st.xlvl <= 1'b0;
         st.pre <= 16'h0000;
         st.sec <= `SRA_SEC_RST;
         st.alm <= {`SRA_ALARM_RST, `SRA_ALARM_RST};
         st.tally <= `SRA_TALLY_SEED;
         st.valid <= 1'b0;
         st.busy_cnt <= 5'h00;
         st.alm_en <= 1'b0;
         st.sel <= `SRA_SEL_OFF;
         st.pcnt <= 7'h00;
         st.irq_stat <= 2'h0;
         st.irq_mask <= 2'h0;
         st.irq <= 1'b0;
         st.rdata <= 16'h0000;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // *****************************************************
   // Outputs
   // *****************************************************
   assign rdata_o = st.rdata;
   assign irq_o = st.irq;

endmodule

// file: verification/sra_props.sv
// Port checker and bind for the seconds RTC block
`timescale 1ns/1ps
`include "sra_defs.svh"
module sra_props
   import sra_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire sra_bus_s bus_i,
   input wire logic [15:0] rdata_o,
   input wire logic irq_o
);
   // Address of an accepted request, 0 when none; no register sits at 0
   logic [15:0] wa;
   logic [15:0] ra;
   assign wa = (ce_i & bus_i.wr) ? bus_i.addr : 16'h0000;
   assign ra = (ce_i & bus_i.rd) ? bus_i.addr : 16'h0000;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_idle_rd_zero: assert property (ce_i && !bus_i.rd |=> rdata_o == 16'h0000)
      else $error("read data outside a read");
   a_alm_hi_back: assert property (
      wa == `SRA_ADDR_ALM_HI ##2 ra == `SRA_ADDR_ALM_HI |=> rdata_o == $past(bus_i.wdata, 3))
      else $error("alarm high readback");
   a_alm_lo_back: assert property (
      wa == `SRA_ADDR_ALM_LO ##2 ra == `SRA_ADDR_ALM_LO |=> rdata_o == $past(bus_i.wdata, 3))
      else $error("alarm low readback");
   a_sec_lo_back: assert property (
      wa == `SRA_ADDR_SEC_LO ##2 ra == `SRA_ADDR_SEC_LO |=> rdata_o == $past(bus_i.wdata, 3))
      else $error("seconds low readback");
   a_tally_ro: assert property (
      ra == `SRA_ADDR_TALLY ##2 wa == `SRA_ADDR_TALLY ##2 ra == `SRA_ADDR_TALLY
      |=> rdata_o == $past(rdata_o, 4)) else $error("tally took a write");
   a_tally_step: assert property (
      ra == `SRA_ADDR_TALLY ##2 wa == `SRA_ADDR_SEC_LO ##2 ra == `SRA_ADDR_TALLY
      |=> rdata_o != $past(rdata_o, 4)) else $error("tally did not change");
   a_valid_set: assert property (
      wa == `SRA_ADDR_SEC_HI ##2 ra == `SRA_ADDR_CTRL |=> rdata_o[15:14] == 2'b11)
      else $error("valid or busy not set");
   a_mask_quiet: assert property (
      wa == `SRA_ADDR_IRQ_MASK && bus_i.wdata[1:0] == 2'b00 |=> !irq_o)
      else $error("interrupt high while masked");
endmodule
bind sra_top sra_props u_sra_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o));

// file: verification/testbench.sv
// Self-checking bench for the seconds RTC block
`timescale 1ns/1ps
`include "sra_defs.svh"
module testbench
   import sra_pkg::*;
;
   // Short second keeps the run brief; a tick is XPS crystal rises
   localparam int XPS = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic xtal_i = 1'b0;
   logic ce_i = 1'b1;
   sra_bus_s bus_i = '0;
   logic [15:0] rdata_o;
   logic irq_o;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] m_sec;
   logic [31:0] alm;
   logic [15:0] m_tly = `SRA_TALLY_SEED;
   logic [15:0] v;
   logic [15:0] h;
   always #5 clk_i = ~clk_i;
   sra_top #(.XTAL_PER_SEC(XPS)) u_sra_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .xtal_i(xtal_i), .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o));
   task automatic ck(string n, logic [15:0] s, logic [15:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] d);
      bus_i.addr <= a;
      bus_i.wdata <= d;
      bus_i.wr <= 1'b1;
      @(posedge clk_i);
      bus_i.wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(logic [15:0] a);
      bus_i.addr <= a;
      bus_i.rd <= 1'b1;
      @(posedge clk_i);
      bus_i.rd <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic wsec(logic [15:0] a, logic [15:0] d, logic [15:0] ra);
      wr(a, d);
      m_tly = (m_tly >> 1) ^ (m_tly[0] ? `SRA_TALLY_TAPS : 16'h0000);
      rd(ra);
      // Host stays off the clock registers until the busy flag has surely dropped
      repeat (24) @(posedge clk_i);
   endtask
   task automatic tk(int n);
      repeat (n * XPS) begin
         xtal_i <= 1'b1;
         repeat (5) @(posedge clk_i);
         xtal_i <= 1'b0;
         repeat (5) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
      m_sec += n;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 16000) begin
         num_errors++;
         stop_test;
      end
   end
   initial begin
      void'($urandom(32'h9FD7));
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 16'h4020; a <= 16'h4031; a++) begin
         rd(16'(a));
         ck("reset", v, a == 16'h4020 ? `SRA_TALLY_SEED : 16'h0000);
      end
      rd(`SRA_ADDR_TALLY);
      wr(`SRA_ADDR_TALLY, 16'($urandom));
      rd(`SRA_ADDR_TALLY);
      ck("tally", v, m_tly);
      for (int i = 0; i < 2; i++) begin
         h = 16'($urandom);
         wr(16'(`SRA_ADDR_ALM_HI + i), h);
         rd(16'(`SRA_ADDR_ALM_HI + i));
         ck("alarm", v, h);
      end
      $display("done: registers");
      m_sec = {16'($urandom), 1'b0, 15'($urandom)};
      rd(`SRA_ADDR_TALLY);
      wsec(`SRA_ADDR_SEC_LO, m_sec[15:0], `SRA_ADDR_TALLY);
      ck("tally", v, m_tly);
      wsec(`SRA_ADDR_SEC_HI, m_sec[31:16], `SRA_ADDR_CTRL);
      ck("valid", v & 16'hC000, 16'hC000);
      wsec(`SRA_ADDR_SEC_LO, m_sec[15:0], `SRA_ADDR_SEC_LO);
      ck("sec_lo", v, m_sec[15:0]);
      tk(3);
      rd(`SRA_ADDR_SEC_HI);
      ck("sec_hi", v, m_sec[31:16]);
      rd(`SRA_ADDR_SEC_LO);
      ck("sec_lo", v, m_sec[15:0]);
      $display("done: seconds");
      alm = m_sec + 32'h0000_0002;
      wr(`SRA_ADDR_IRQ_MASK, 16'h0003);
      wr(`SRA_ADDR_ALM_HI, alm[31:16]);
      wr(`SRA_ADDR_ALM_LO, alm[15:0]);
      wr(`SRA_ADDR_CTRL, 16'h0400);
      tk(1);
      ck("irq", 16'(irq_o), 16'h0000);
      tk(1);
      ck("irq", 16'(irq_o), 16'h0001);
      rd(`SRA_ADDR_IRQ_STAT);
      ck("status", v, 16'h0001);
      wr(`SRA_ADDR_IRQ_MASK, 16'h0000);
      ck("irq", 16'(irq_o), 16'h0000);
      wr(`SRA_ADDR_IRQ_STAT, 16'h0001);
      rd(`SRA_ADDR_IRQ_STAT);
      ck("status", v, 16'h0000);
      wr(`SRA_ADDR_IRQ_MASK, 16'h0003);
      $display("done: alarm");
      for (int s = 0; s < 8; s++) begin
         wr(`SRA_ADDR_CTRL, 16'(s << 4));
         tk((1 << s) - 1);
         rd(`SRA_ADDR_IRQ_STAT);
         ck("period", v, 16'h0000);
         tk(1);
         rd(`SRA_ADDR_IRQ_STAT);
         ck("period", v, s != 0 ? 16'h0002 : 16'h0000);
         ck("irq", 16'(irq_o), s != 0 ? 16'h0001 : 16'h0000);
         wr(`SRA_ADDR_IRQ_STAT, 16'h0002);
      end
      $display("done: periodic");
      // A write while the clock enable is low must leave no trace
      ce_i <= 1'b0;
      wr(`SRA_ADDR_ALM_LO, 16'($urandom));
      ce_i <= 1'b1;
      rd(`SRA_ADDR_ALM_LO);
      ck("freeze", v, alm[15:0]);
      $display("done: freeze");
      stop_test;
   end
endmodule
